// ===== core/aje_exec.sv
// Execution unit for arithmetic, logic, multiply, jump and call operations of the 8-bit core.
`timescale 1ns/1ps
//
// Behaviour
// - Add with carry updates all six flags.
// - Word immediate add on register pair, one cycle.
// - Subtract registers, flags updated, one cycle.
// - Subtract with borrow, flags updated, one cycle.
// - Immediate subtract with borrow, one cycle.
// - Immediate and updates Z N V S only.
// - Immediate or updates Z N V S only.
// - Test leaves register, sets Z N V.
// - Set all ones, flags unchanged.
// - Fractional multiply shifted into R1:R0, Z C.
// - Pointer jump from pair, two cycles.
// - Relative call: PC plus offset plus one.
// - Pointer call from pair, two cycles.
module aje_exec (
    input  wire logic                              I_CORE_CLK,
    input  wire logic                              I_RSTN,
    input  wire logic                              I_OP_VALID,
    input  wire logic [aje_pkg::AJE_OP_W-1:0]      I_OP,
    input  wire logic [aje_pkg::AJE_REG_SEL_W-1:0] I_RD,
    input  wire logic [aje_pkg::AJE_REG_SEL_W-1:0] I_RR,
    input  wire logic [7:0]                        I_IMM,
    input  wire logic [aje_pkg::AJE_OFFSET_W-1:0]  I_OFFSET,
    input  wire logic [aje_pkg::AJE_REG_SEL_W-1:0] I_PEEK_SEL,
    output logic                                   O_BUSY,
    output logic                                   O_DONE,
    output logic [aje_pkg::AJE_PC_W-1:0]           O_PC,
    output logic [7:0]                             O_SREG,
    output logic [aje_pkg::AJE_SP_W-1:0]           O_SP,
    output logic [7:0]                             O_PEEK
);
    import aje_pkg::*;

    // A request is taken at an edge where the unit is idle.
    // One-cycle ops commit at that edge.
    // Done then pulses for one cycle.
    // Pointer ops spend one extra busy cycle.
    // The target is held in tgt meanwhile.
    // The counter stays put while busy.
    // Requests during busy are dropped.
    // Nothing flags a dropped request.
    // The issuer must watch busy itself.
    // The stack has eight flop slots.
    // It wraps with no overflow error.
    // Deep call chains lose old entries.
    // That trade keeps the stack small.
    // Peek reads any register for tests.
    // It lags its select by one edge.
    // Status bits six and seven stay zero.
    // No op here writes those two bits.

    aje_state_s_t q;          // Registered state.
    aje_state_s_t d;          // Next state.

    logic [7:0]  opa;         // Destination operand.
    logic [7:0]  opb;         // Source operand or constant.
    logic        adder_cin;   // Carry or borrow into the adder.
    logic        adder_sub;   // High for subtraction.
    logic [7:0]  adder_res;   // Adder result.
    logic        adder_c;     // Carry or borrow out.
    logic        adder_h;     // Half carry out.
    logic        adder_v;     // Overflow out.
    logic [15:0] word_old;    // Register pair before the word add.
    logic [16:0] word_sum;    // Word sum with carry.
    logic [17:0] product;     // Signed product of extended operands.
    logic [8:0]  mul_a;       // Extended multiplicand.
    logic [8:0]  mul_b;       // Extended multiplier.
    logic        a_signed;    // Multiplicand taken as signed.
    logic        b_signed;    // Multiplier taken as signed.
    logic [15:0] rel_target;  // Target of the relative call.
    logic [4:0]  rd_hi;       // Upper register of the word pair.

    // Logic ops never touch C or H.
    // The helper copies the old status.
    // It then patches Z, N, V and S.
    // One function keeps and, or and test alike.
    // Sets Z and N from a byte, clears V and keeps S consistent.
    function automatic logic [7:0] logic_flags(input logic [7:0] s, input logic [7:0] r);
        logic [7:0] f;
        f              = s;
        f[AJE_SREG_Z]  = (r == 8'h00);
        f[AJE_SREG_N]  = r[7];
        f[AJE_SREG_V]  = 1'b0;
        f[AJE_SREG_S]  = r[7];
        return f;
    endfunction

    // Only the with-carry forms use the stored carry.
    // Plain add and subtract use a zero carry.
    // Only the immediate borrow form reads the constant.
    // The others read the source register.
    // Operand selection for the shared adder.
    always_comb begin
        opa       = q.gpr[I_RD];
        opb       = (I_OP == AJE_OP_IMM_SUBTRACT_BORROW) ? I_IMM : q.gpr[I_RR];
        adder_cin = 1'b0;
        adder_sub = 1'b0;
        if (I_OP == AJE_OP_ADD_CARRY || I_OP == AJE_OP_SUBTRACT_BORROW || I_OP == AJE_OP_IMM_SUBTRACT_BORROW) begin
            adder_cin = q.sreg[AJE_SREG_C];
        end
        if (I_OP == AJE_OP_SUBTRACT || I_OP == AJE_OP_SUBTRACT_BORROW || I_OP == AJE_OP_IMM_SUBTRACT_BORROW) begin
            adder_sub = 1'b1;
        end
    end

    // Only the byte arithmetic ops use the adder flags.
    // Other ops ignore its outputs.
    // Its inputs still toggle then.
    // That costs a little power.
    // It saves a second adder.
    // One adder serves every byte add and subtract; it keeps the flag logic in one place.
    aje_addsub u_addsub (
        .i_a   (opa),
        .i_b   (opb),
        .i_cin (adder_cin),
        .i_sub (adder_sub),
        .o_res (adder_res),
        .o_c   (adder_c),
        .o_h   (adder_h),
        .o_v   (adder_v)
    );

    // The multiplier works on nine bits.
    // Each operand gets an extra sign bit.
    // Unsigned operands get a zero there.
    // One signed product covers all forms.
    // That spares three separate arrays.
    // The word add uses six bits of the constant.
    // Upper constant bits are ignored.
    // Word add, multiplier and relative call target.
    always_comb begin
        rd_hi    = {I_RD[4:1], 1'b1};
        word_old = {q.gpr[rd_hi], q.gpr[{I_RD[4:1], 1'b0}]};
        word_sum = {1'b0, word_old} + {11'h000, I_IMM[5:0]};
        a_signed = (I_OP == AJE_OP_FRACTIONAL_SIGNED) || (I_OP == AJE_OP_FRACTIONAL_MIXED);
        b_signed = (I_OP == AJE_OP_FRACTIONAL_SIGNED);
        mul_a    = {a_signed & opa[7], opa};
        mul_b    = {b_signed & q.gpr[I_RR][7], q.gpr[I_RR]};
        product  = 18'($signed(mul_a) * $signed(mul_b));
        rel_target = q.pc + {{4{I_OFFSET[11]}}, I_OFFSET} + AJE_PC_STEP;
    end

    // Next-state logic: one-cycle operations finish at the accepting edge, pointer ops take a second edge.
    always_comb begin
        d      = q;
        d.done = 1'b0;
        d.peek = q.gpr[I_PEEK_SEL];
        unique case (q.st)
            AJE_ST_IDLE: begin
                if (I_OP_VALID) begin
                    d.done = 1'b1;
                    d.pc   = q.pc + AJE_PC_STEP;
                    case (I_OP)
                        AJE_OP_ADD, AJE_OP_ADD_CARRY, AJE_OP_SUBTRACT, AJE_OP_SUBTRACT_BORROW,
                        AJE_OP_IMM_SUBTRACT_BORROW: begin
                            // Result and all six arithmetic flags.
                            d.gpr[I_RD]          = adder_res;
                            d.sreg[AJE_SREG_C]   = adder_c;
                            d.sreg[AJE_SREG_H]   = adder_h;
                            d.sreg[AJE_SREG_V]   = adder_v;
                            d.sreg[AJE_SREG_N]   = adder_res[7];
                            d.sreg[AJE_SREG_Z]   = (adder_res == 8'h00);
                            d.sreg[AJE_SREG_S]   = adder_res[7] ^ adder_v;
                        end
                        AJE_OP_WORD_IMMEDIATE_ADD: begin
                            // Both halves of the pair are written in the same cycle.
                            d.gpr[{I_RD[4:1], 1'b0}] = word_sum[7:0];
                            d.gpr[rd_hi]             = word_sum[15:8];
                            d.sreg[AJE_SREG_C]       = word_sum[16];
                            d.sreg[AJE_SREG_Z]       = (word_sum[15:0] == 16'h0000);
                            d.sreg[AJE_SREG_N]       = word_sum[15];
                            d.sreg[AJE_SREG_V]       = ~word_old[15] & word_sum[15];
                            d.sreg[AJE_SREG_S]       = word_sum[15] ^ (~word_old[15] & word_sum[15]);
                        end
                        AJE_OP_IMMEDIATE_AND: begin
                            d.gpr[I_RD] = opa & I_IMM;
                            d.sreg      = logic_flags(q.sreg, opa & I_IMM);
                        end
                        AJE_OP_IMMEDIATE_OR: begin
                            d.gpr[I_RD] = opa | I_IMM;
                            d.sreg      = logic_flags(q.sreg, opa | I_IMM);
                        end
                        AJE_OP_TEST_VALUE: begin
                            // The register is and-ed with itself, so only flags change.
                            d.sreg = logic_flags(q.sreg, opa & opa);
                        end
                        AJE_OP_SET_ALL_ONES: begin
                            d.gpr[I_RD] = AJE_ALL_ONES;
                        end
                        AJE_OP_MULTIPLY: begin
                            d.gpr[0]           = product[7:0];
                            d.gpr[1]           = product[15:8];
                            d.sreg[AJE_SREG_C] = product[15];
                            d.sreg[AJE_SREG_Z] = (product[15:0] == 16'h0000);
                        end
                        AJE_OP_FRACTIONAL_MULTIPLY, AJE_OP_FRACTIONAL_SIGNED, AJE_OP_FRACTIONAL_MIXED: begin
                            // Carry takes the bit shifted out; zero is judged after the shift.
                            d.gpr[0]           = {product[6:0], 1'b0};
                            d.gpr[1]           = product[14:7];
                            d.sreg[AJE_SREG_C] = product[15];
                            d.sreg[AJE_SREG_Z] = (product[14:0] == 15'h0000);
                        end
                        AJE_OP_RELATIVE_CALL: begin
                            // Return address goes on the stack in the same cycle as the jump.
                            d.stk[q.sp] = q.pc + AJE_PC_STEP;
                            d.sp        = q.sp + 3'h1;
                            d.pc        = rel_target;
                        end
                        AJE_OP_POINTER_JUMP: begin
                            d.tgt  = {q.gpr[AJE_PTR_HI], q.gpr[AJE_PTR_LO]};
                            d.pc   = q.pc;
                            d.st   = AJE_ST_SECOND;
                            d.busy = 1'b1;
                            d.done = 1'b0;
                        end
                        AJE_OP_POINTER_CALL: begin
                            // First cycle pushes, second loads the pointer.
                            d.stk[q.sp] = q.pc + AJE_PC_STEP;
                            d.sp        = q.sp + 3'h1;
                            d.tgt       = {q.gpr[AJE_PTR_HI], q.gpr[AJE_PTR_LO]};
                            d.pc        = q.pc;
                            d.st        = AJE_ST_SECOND;
                            d.busy      = 1'b1;
                            d.done      = 1'b0;
                        end
                        AJE_OP_RETURN: begin
                            // Pops in the reverse order of the push; the stack wraps when overused.
                            d.sp   = q.sp - 3'h1;
                            d.tgt  = q.stk[q.sp - 3'h1];
                            d.pc   = q.pc;
                            d.st   = AJE_ST_SECOND;
                            d.busy = 1'b1;
                            d.done = 1'b0;
                        end
                        AJE_OP_LOAD_IMMEDIATE: begin
                            d.gpr[I_RD] = I_IMM;
                        end
                        default: begin
                            // Unknown opcodes behave as a no-operation and still advance.
                            d.pc = q.pc + AJE_PC_STEP;
                        end
                    endcase
                end
            end
            AJE_ST_SECOND: begin
                d.pc   = q.tgt;
                d.st   = AJE_ST_IDLE;
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        endcase
    end

    // Reset clears every register.
    // The state is one packed struct.
    // So a single flop bank holds it.
    // Reset drives constants only.
    // Data-dependent reset values would race release.
    // The counter restarts at zero.
    // The stack index restarts at zero.
    // Stale stack slots are cleared too.
    // A pending pointer op is abandoned.
    // State register; the register file holds no reset-time strap, only constants.
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            q      <= '0;
            q.st   <= AJE_ST_IDLE;
            q.sreg <= AJE_SREG_RST;
            q.pc   <= AJE_PC_RST;
        end else begin
            q <= d;
        end
    end

    // No output passes through logic.
    // Each one is a plain flop bit.
    // So outputs never glitch.
    // Done is high for one cycle per completion.
    // Busy is high for one cycle only.
    // They are never high together.
    // Outputs come straight from the state flops.
    assign O_BUSY = q.busy;
    assign O_DONE = q.done;
    assign O_PC   = q.pc;
    assign O_SREG = q.sreg;
    assign O_SP   = q.sp;
    assign O_PEEK = q.peek;

endmodule // aje_exec

// ===== core/aje_pkg.sv
// Package with opcodes, status bit positions, reset values and state types of the execution block.
package aje_pkg;

    // Opcode width and the opcodes presented by the decoder.
    localparam int unsigned AJE_OP_W                  = 5;
    localparam logic [4:0] AJE_OP_ADD                 = 5'h00;
    localparam logic [4:0] AJE_OP_ADD_CARRY           = 5'h01;
    localparam logic [4:0] AJE_OP_WORD_IMMEDIATE_ADD  = 5'h02;
    localparam logic [4:0] AJE_OP_SUBTRACT            = 5'h03;
    localparam logic [4:0] AJE_OP_SUBTRACT_BORROW     = 5'h04;
    localparam logic [4:0] AJE_OP_IMM_SUBTRACT_BORROW = 5'h05;
    localparam logic [4:0] AJE_OP_IMMEDIATE_AND       = 5'h06;
    localparam logic [4:0] AJE_OP_IMMEDIATE_OR        = 5'h07;
    localparam logic [4:0] AJE_OP_TEST_VALUE          = 5'h08;
    localparam logic [4:0] AJE_OP_SET_ALL_ONES        = 5'h09;
    localparam logic [4:0] AJE_OP_MULTIPLY            = 5'h0a;
    localparam logic [4:0] AJE_OP_FRACTIONAL_MULTIPLY = 5'h0b;
    localparam logic [4:0] AJE_OP_FRACTIONAL_SIGNED   = 5'h0c;
    localparam logic [4:0] AJE_OP_FRACTIONAL_MIXED    = 5'h0d;
    localparam logic [4:0] AJE_OP_POINTER_JUMP        = 5'h0e;
    localparam logic [4:0] AJE_OP_RELATIVE_CALL       = 5'h0f;
    localparam logic [4:0] AJE_OP_POINTER_CALL        = 5'h10;
    localparam logic [4:0] AJE_OP_RETURN              = 5'h11;
    localparam logic [4:0] AJE_OP_LOAD_IMMEDIATE      = 5'h12;

    // Field widths.
    localparam int unsigned AJE_REG_SEL_W = 5;
    localparam int unsigned AJE_OFFSET_W  = 12;
    localparam int unsigned AJE_PC_W      = 16;
    localparam int unsigned AJE_STK_DEPTH = 8;
    localparam int unsigned AJE_SP_W      = 3;

    // Status register bit positions.
    localparam int unsigned AJE_SREG_C = 0;
    localparam int unsigned AJE_SREG_Z = 1;
    localparam int unsigned AJE_SREG_N = 2;
    localparam int unsigned AJE_SREG_V = 3;
    localparam int unsigned AJE_SREG_S = 4;
    localparam int unsigned AJE_SREG_H = 5;

    // The index pointer is the register pair 31:30.
    localparam logic [4:0] AJE_PTR_LO = 5'h1e;
    localparam logic [4:0] AJE_PTR_HI = 5'h1f;

    // Fixed results and reset values.
    localparam logic [7:0]  AJE_ALL_ONES   = 8'hff;
    localparam logic [7:0]  AJE_SREG_RST   = 8'h00;
    localparam logic [15:0] AJE_PC_RST     = 16'h0000;
    localparam logic [15:0] AJE_PC_STEP    = 16'h0001;

    // Execution states.
    typedef enum logic [0:0] {
        AJE_ST_IDLE,
        AJE_ST_SECOND
    } aje_state_t;

    // Whole state of the execution block.
    typedef struct packed {
        aje_state_t                            st;
        logic [31:0][7:0]                      gpr;
        logic [7:0]                            sreg;
        logic [15:0]                           pc;
        logic [15:0]                           tgt;
        logic [AJE_STK_DEPTH-1:0][15:0]        stk;
        logic [AJE_SP_W-1:0]                   sp;
        logic                                  busy;
        logic                                  done;
        logic [7:0]                            peek;
    } aje_state_s_t;

endpackage

// ===== core/aje_addsub.sv
// Eight-bit adder and subtractor with carry, half-carry and overflow outputs.
`timescale 1ns/1ps
module aje_addsub (
    input  wire logic [7:0] i_a,
    input  wire logic [7:0] i_b,
    input  wire logic       i_cin,
    input  wire logic       i_sub,
    output logic      [7:0] o_res,
    output logic            o_c,
    output logic            o_h,
    output logic            o_v
);
    logic [8:0] sum;  // Nine bits so the top bit is carry or borrow.

    // Borrow on subtraction falls out of the nine-bit wrap as a one in the top bit.
    always_comb begin
        if (i_sub) begin
            sum = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_cin};
        end else begin
            sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
        end
        o_res = sum[7:0];
        o_c   = sum[8];
        if (i_sub) begin
            o_h = (~i_a[3] & i_b[3]) | (i_b[3] & sum[3]) | (sum[3] & ~i_a[3]);
            o_v = (i_a[7] & ~i_b[7] & ~sum[7]) | (~i_a[7] & i_b[7] & sum[7]);
        end else begin
            o_h = (i_a[3] & i_b[3]) | (i_b[3] & ~sum[3]) | (~sum[3] & i_a[3]);
            o_v = (i_a[7] & i_b[7] & ~sum[7]) | (~i_a[7] & ~i_b[7] & sum[7]);
        end
    end
endmodule // aje_addsub

// ===== tb/aje_exec_properties.sv
// Concurrent checks on the ports of the execution unit, bound to its top module.
`timescale 1ns/1ps
module aje_exec_checker import aje_pkg::*; (
    input wire logic                     I_CORE_CLK,
    input wire logic                     I_RSTN,
    input wire logic                     I_OP_VALID,
    input wire logic [AJE_OP_W-1:0]      I_OP,
    input wire logic [AJE_OFFSET_W-1:0]  I_OFFSET,
    input wire logic                     O_BUSY,
    input wire logic                     O_DONE,
    input wire logic [AJE_PC_W-1:0]      O_PC,
    input wire logic [7:0]               O_SREG,
    input wire logic [AJE_SP_W-1:0]      O_SP
);
    // A request is taken on any edge where the unit is not busy.
    wire logic        tk  = I_OP_VALID && !O_BUSY;
    // Pointer jump, pointer call and return occupy two cycles.
    wire logic        two = I_OP inside {5'h0e, 5'h10, 5'h11};
    // Target of a relative call, formed from the current program counter.
    wire logic [15:0] rel = O_PC + {{4{I_OFFSET[11]}}, I_OFFSET} + 16'h0001;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RSTN);
    a_single_cycle_done: assert property (tk && !two |=> O_DONE && !O_BUSY)
        else $error("one-cycle operation gave no done pulse");
    a_pointer_two_cycles: assert property (tk && two |=> O_BUSY && !O_DONE ##1 O_DONE && !O_BUSY)
        else $error("pointer operation did not take two cycles");
    a_jump_keeps_flags: assert property (tk && I_OP == 5'h0e |=> $stable(O_SREG) ##1 $stable(O_SREG))
        else $error("pointer jump changed the status");
    a_call_pushes_stack: assert property (tk && I_OP inside {5'h0f, 5'h10} |=> O_SP == $past(O_SP) + 3'h1)
        else $error("call did not push the return address");
    a_relative_call_target: assert property (tk && I_OP == 5'h0f |=> O_PC == $past(rel))
        else $error("relative call target wrong");
    a_set_ones_flags: assert property (tk && I_OP == 5'h09 |=> O_SREG == $past(O_SREG))
        else $error("set all ones changed the status");
    a_logic_op_flags: assert property (tk && I_OP inside {5'h06, 5'h07, 5'h08}
        |=> !O_SREG[3] && O_SREG[4] == O_SREG[2] && (O_SREG & 8'h21) == ($past(O_SREG) & 8'h21))
        else $error("logic operation flags wrong");
    a_plain_pc_step: assert property (tk && !two && I_OP != 5'h0f |=> O_PC == $past(O_PC) + 16'h0001)
        else $error("program counter did not step by one");
    // Main scenarios that the run should reach.
    c_pointer_call: cover property (tk && I_OP == 5'h10 ##2 O_DONE);
    c_relative_call: cover property (tk && I_OP == 5'h0f);
    c_back_to_back: cover property (O_DONE ##1 O_DONE);
endmodule // aje_exec_checker

bind aje_exec aje_exec_checker i_chk (.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_OP_VALID(I_OP_VALID),
    .I_OP(I_OP), .I_OFFSET(I_OFFSET), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_PC(O_PC), .O_SREG(O_SREG),
    .O_SP(O_SP));

// ===== tb/aje_exec_tb.sv
// Self-checking testbench for the execution unit, with a reference model and result queue.
`timescale 1ns/1ps
module aje_exec_tb;
    import aje_pkg::*;
    // One expected result: program counter, status and stack index.
    typedef struct packed {logic [15:0] pc; logic [7:0] sr; logic [2:0] sp;} aje_note_t;
    logic        clk, rstn, vld, busy, done;
    logic [4:0]  op, rd, rr, psel;
    logic [7:0]  imm, sreg, peek;
    logic [11:0] off;
    logic [15:0] pc;
    logic [2:0]  sp;
    logic [7:0]  g [32];      // Model registers.
    logic [15:0] k [8];       // Model return stack.
    logic [7:0]  s;           // Model status.
    logic [15:0] p;           // Model program counter.
    logic [2:0]  m_sp;        // Model stack index.
    aje_note_t   q [$];       // Expected results in issue order.
    int          n_errors = 0;
    int          samples_checked = 0;

    aje_exec i_dut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_OP_VALID(vld), .I_OP(op), .I_RD(rd), .I_RR(rr),
        .I_IMM(imm), .I_OFFSET(off), .I_PEEK_SEL(psel), .O_BUSY(busy), .O_DONE(done), .O_PC(pc),
        .O_SREG(sreg), .O_SP(sp), .O_PEEK(peek));

    // Compares one completion record.
    task automatic cmp_note(input aje_note_t got, input aje_note_t exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compares one register byte.
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Zero, negative and sign flags from a byte result.
    task automatic zn(input logic [7:0] v);
        s[1] = (v == 8'h00);
        s[2] = v[7];
        s[4] = s[2] ^ s[3];
    endtask

    // Byte add or subtract with carry in, all six flags.
    task automatic arith(input logic [7:0] b, input logic cin, input logic sub, input logic [4:0] d);
        logic [8:0] r;
        logic [4:0] h;
        logic [7:0] a;
        a = g[d];
        r = sub ? {1'b0, a} - b - cin : a + b + cin;
        h = sub ? {1'b0, a[3:0]} - b[3:0] - cin : a[3:0] + b[3:0] + cin;
        g[d] = r[7:0];
        s[0] = r[8];
        s[5] = h[4];
        s[3] = sub ? (a[7] ^ b[7]) & (r[7] ^ a[7]) : ~(a[7] ^ b[7]) & (r[7] ^ a[7]);
        zn(r[7:0]);
    endtask

    // Updates the model, notes the result, then issues the request at this edge.
    task automatic run(input logic [4:0] o, input logic [4:0] d, input logic [4:0] r, input logic [7:0] i,
                       input logic [11:0] f);
        logic [15:0] z;
        logic [15:0] m;
        logic [16:0] w;
        logic [4:0]  lo;
        z = {g[31], g[30]};
        lo = {d[4:1], 1'b0};
        case (o)
            5'h00: arith(g[r], 1'b0, 1'b0, d);
            5'h01: arith(g[r], s[0], 1'b0, d);
            5'h02: begin
                m = {g[lo + 5'h01], g[lo]};
                w = m + i[5:0];
                {g[lo + 5'h01], g[lo]} = w[15:0];
                s[0] = w[16];
                s[3] = ~m[15] & w[15];
                s[1] = (w[15:0] == 16'h0000);
                s[2] = w[15];
                s[4] = s[2] ^ s[3];
            end
            5'h03: arith(g[r], 1'b0, 1'b1, d);
            5'h04: arith(g[r], s[0], 1'b1, d);
            5'h05: arith(i, s[0], 1'b1, d);
            5'h06, 5'h07, 5'h08: begin
                if (o == 5'h06) g[d] = g[d] & i;
                if (o == 5'h07) g[d] = g[d] | i;
                s[3] = 1'b0;
                zn(g[d]);
            end
            5'h09: g[d] = 8'hff;
            5'h0a, 5'h0b, 5'h0c, 5'h0d: begin
                if (o == 5'h0c) m = $signed(g[d]) * $signed(g[r]);
                else if (o == 5'h0d) m = $signed(g[d]) * $signed({1'b0, g[r]});
                else m = g[d] * g[r];
                s[0] = m[15];
                if (o != 5'h0a) m = m << 1;
                s[1] = (m == 16'h0000);
                {g[1], g[0]} = m;
            end
            5'h0e: p = z;
            5'h0f, 5'h10: begin
                k[m_sp] = p + 16'h0001;
                m_sp = m_sp + 3'h1;
                p = (o == 5'h10) ? z : p + {{4{f[11]}}, f} + 16'h0001;
            end
            5'h11: begin
                m_sp = m_sp - 3'h1;
                p = k[m_sp];
            end
            5'h12: g[d] = i;
            default: ;
        endcase
        // Every operation other than a jump, call or return steps the counter by one.
        if (!(o inside {5'h0e, 5'h0f, 5'h10, 5'h11})) p = p + 16'h0001;
        q.push_back('{p, s, m_sp});
        op <= o;
        rd <= d;
        rr <= r;
        imm <= i;
        off <= f;
        vld <= 1'b1;
        @(posedge clk);
        // The request stays up through the busy cycle, where it must be ignored.
        if (o inside {5'h0e, 5'h10, 5'h11}) @(posedge clk);
    endtask

    // Reads back every register through the observation port.
    task automatic peek_all();
        for (int i = 0; i < 32; i++) begin
            psel <= i[4:0];
            @(posedge clk);
            @(negedge clk);
            cmp_byte(peek, g[i]);
            @(posedge clk);
        end
    endtask

    // Holds reset for three cycles and clears the model to match.
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        g = '{default: 8'h00};
        k = '{default: 16'h0000};
        s = 8'h00;
        p = 16'h0000;
        m_sp = 3'h0;
        q.delete();
    endtask

    // Random operations, issued back to back, then a register sweep.
    task automatic burst(input int n);
        repeat (n) run(5'($urandom % 24), 5'($urandom), 5'($urandom), 8'($urandom), 12'($urandom));
        vld <= 1'b0;
        peek_all();
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Free-running 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Each completion pulse retires the oldest expected result.
    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (q.size() == 0) cmp_note({pc, sreg, sp}, 'x);
            else cmp_note({pc, sreg, sp}, q.pop_front());
        end
    end

    // Main sequence.
    initial begin
        vld = 1'b0;
        op = 5'h00;
        rd = 5'h00;
        rr = 5'h00;
        imm = 8'h00;
        off = 12'h000;
        psel = 5'h00;
        void'($urandom(40084));
        do_reset();
        for (int i = 0; i < 32; i++) run(5'h12, i[4:0], 5'h00, 8'($urandom), 12'h000);
        for (int n = 0; n < 20; n++) burst(20);
        $display("test random operations done");
        do_reset();
        cmp_note({pc, sreg, sp}, '0);
        peek_all();
        burst(30);
        $display("test reset in mid-run done");
        if (q.size() != 0) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, q.size(), 0);
        end
        conclude();
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        #(40000 * 50);
        n_errors++;
        conclude();
    end
endmodule // aje_exec_tb
